// ===== ppic_pkg.sv
// ppic_pkg: register map, field layout and reset values of the port block
`default_nettype none
package ppic_pkg;
	// register byte offsets on the apb window
	localparam logic [7:0] OFF_DIR = 8'h00;
	localparam logic [7:0] OFF_DATA = 8'h04;
	localparam logic [7:0] OFF_DATA_SET = 8'h08;
	localparam logic [7:0] OFF_DATA_CLR = 8'h0C;
	localparam logic [7:0] OFF_PIN_IN = 8'h10;
	localparam logic [7:0] OFF_GMASK = 8'h14;
	localparam logic [7:0] OFF_GEDGE = 8'h18;
	localparam logic [7:0] OFF_GBOTH = 8'h1C;
	localparam logic [7:0] OFF_GSWTRIG = 8'h20;
	localparam logic [7:0] OFF_GSTAT = 8'h24;
	localparam logic [7:0] OFF_MUX_LO = 8'h28;
	localparam logic [7:0] OFF_MUX_HI = 8'h2C;
	localparam logic [7:0] OFF_FER = 8'h30;
	// channel register block: base + channel * stride
	localparam logic [7:0] OFF_CH_BASE = 8'h40;
	localparam logic [7:0] CH_STRIDE = 8'h20;
	localparam logic [4:0] CH_ASSIGN = 5'h00;
	localparam logic [4:0] CH_MASK_SET = 5'h04;
	localparam logic [4:0] CH_MASK_CLR = 5'h08;
	localparam logic [4:0] CH_REQ = 5'h0C;
	localparam logic [4:0] CH_LATCH = 5'h10;
	localparam logic [4:0] CH_EDGE_SET = 5'h14;
	localparam logic [4:0] CH_EDGE_CLR = 5'h18;
	localparam logic [4:0] CH_INV_SET = 5'h1C;
	// assign register: half-port select per byte lane, bit 7 enables lane
	localparam int ASSIGN_EN_BIT = 7;
	localparam int HALF_PORT_W = 8;
	localparam int FUNC_SEL_W = 2;
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
endpackage : ppic_pkg
`default_nettype wire

// ===== ppic_chan.sv
// ppic_chan: one pin-interrupt channel of four byte lanes
`default_nettype none
module ppic_chan #(
	parameter int NPINS = 32
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [NPINS-1:0] pins_i,
	input wire logic [31:0] assign_i,
	input wire logic [31:0] mask_i,
	input wire logic [31:0] edge_i,
	input wire logic [31:0] inv_i,
	input wire logic [31:0] clr_i,
	output logic [31:0] pin_state_o,
	output logic [31:0] latch_o,
	output logic irq_o
);
	localparam int NHALF = NPINS / ppic_pkg::HALF_PORT_W;
	logic [31:0] prev_ff;
	logic [31:0] lvl;
	logic [31:0] latch_ff;
	logic [31:0] det;

	// a seven-bit half-port index reaches 128 groups at most
	if (NHALF < 1 || NHALF > 128 || NPINS % 8 != 0)
	begin : g_bad_size
		$error("ppic_chan: pin count must be a multiple of eight");
	end

	// gather a half-port per lane, never single pins
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_lane
			logic [7:0] sel;
			logic [NPINS-1:0] sh;
			assign sel = assign_i[g*8 +: 8];
			assign sh = pins_i >> ({3'h0, sel[6:0]} * 8);
			assign pin_state_o[g*8 +: 8] = sel[ppic_pkg::ASSIGN_EN_BIT] ?
				sh[7:0] : 8'h00;
		end
	endgenerate

	// polarity applied before detection
	assign lvl = pin_state_o ^ inv_i;
	assign det = edge_i & lvl & ~prev_ff | ~edge_i & lvl;

	// latch requests; a live event beats a clear, level refires
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			prev_ff <= 32'h0000_0000;
			latch_ff <= 32'h0000_0000;
		end
		else
		begin
			prev_ff <= lvl;
			latch_ff <= (latch_ff & ~clr_i) | det;
		end
	end

	assign latch_o = latch_ff;
	assign irq_o = |(latch_ff & mask_i);
endmodule : ppic_chan
`default_nettype wire

// ===== ppic_top.sv
// ppic_top: gpio port with apb registers and pin-interrupt channels
// What this block does
// - every pin has its own input or output direction bit
// - set and clear aliases change only pins written with one
// - each pin has its own interrupt mask bit
// - inputs interrupt from hardware, outputs only by software trigger
// - per pin level or edge; edge mode rising only or both
// - channel pins detect by edge or level with selectable polarity
// - channel detection ignores port direction and data settings
// - each channel serves up to 32 pins and one interrupt line
// - pins join channels eight at a time as half-ports
// - every channel owns a 32-bit register set
// - channels mask, identify and clear latched requests
// - pin states and latches readable regardless of mask
// - channel mask and edge registers have write-one-set and write-one-clear aliases
// - each pin picks port function or one of four peripherals
//
// Local design decisions: the register offsets and register access over APB.
`default_nettype none
module ppic_top #(
	parameter int NPINS = 32,
	parameter int NCHAN = 4
) (
	input wire logic CLK_SYS_I,
	input wire logic RESETN_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire logic [NPINS-1:0] PIN_I,
	output logic [NPINS-1:0] PIN_O,
	output logic [NPINS-1:0] PIN_OE_O,
	input wire logic [4*NPINS-1:0] PERIPH_OUT_I,
	input wire logic [4*NPINS-1:0] PERIPH_OE_I,
	output logic [NPINS-1:0] PERIPH_IN_O,
	output logic GPIO_IRQ_O,
	output logic [NCHAN-1:0] CHAN_IRQ_O
);
	// port configuration, one bit per pin
	logic [31:0] dir_ff;
	logic [31:0] data_ff;
	logic [31:0] gmask_ff;
	logic [31:0] gedge_ff;
	logic [31:0] gboth_ff;
	// gpio interrupt state and function enables
	logic [31:0] swtrig_ff;
	logic [31:0] gstat_ff;
	logic [31:0] fer_ff;
	logic [63:0] mux_ff;
	// pin sampling pipeline
	logic [31:0] sync1_ff;
	logic [31:0] sync2_ff;
	logic [31:0] gprev_ff;
	logic [31:0] ch_assign_ff [NCHAN];
	logic [31:0] ch_mask_ff [NCHAN];
	logic [31:0] ch_edge_ff [NCHAN];
	logic [31:0] ch_inv_ff [NCHAN];
	logic [31:0] ch_clr [NCHAN];
	logic [31:0] ch_pins [NCHAN];
	logic [31:0] ch_latch [NCHAN];
	logic [31:0] pins32;
	logic [31:0] ghit;
	logic wr;
	logic rd;
	logic [31:0] nxt_rdata;
	logic nxt_err;

	// refuse sizes that the fixed 32-bit register layout cannot serve
	if (NPINS != 32 || NCHAN < 1 || NCHAN > 4)
	begin : g_bad_size
		$error("ppic_top: needs 32 pins and one to four channels");
	end

	// channel index of an address inside the channel window
	function automatic int chan_of(input logic [7:0] a);
		return int'((a - ppic_pkg::OFF_CH_BASE) >> 5);
	endfunction

	// true when address falls inside the register block of some existing channel
	function automatic logic is_chan(input logic [7:0] a);
		return a >= ppic_pkg::OFF_CH_BASE && chan_of(a) < NCHAN;
	endfunction

	// access phase strobes; pready is tied high so every access
	// completes in its first access cycle
	assign wr = PSEL_I & PENABLE_I & PWRITE_I;
	assign rd = PSEL_I & PENABLE_I & ~PWRITE_I;
	assign PREADY_O = 1'b1; // zero wait states
	assign pins32 = sync2_ff;

	// pins are sampled once per clock: a pin change reaches sync2 after
	// two edges, an event bit on the third, the irq output in that same cycle;
	// pulses shorter than one clock may be missed entirely
	// two-flop synchroniser; only the second stage is used
	always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			sync1_ff <= 32'h0000_0000;
			sync2_ff <= 32'h0000_0000;
			gprev_ff <= 32'h0000_0000;
		end
		else
		begin
			sync1_ff <= PIN_I;
			sync2_ff <= sync1_ff;
			gprev_ff <= sync2_ff;
		end
	end

	// writes to read-only or unmapped offsets fall into the default
	// branch and leave every register unchanged
	// port configuration and data registers
	always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			dir_ff <= ppic_pkg::RST_ZERO;
			data_ff <= ppic_pkg::RST_ZERO;
			gmask_ff <= ppic_pkg::RST_ZERO;
			gedge_ff <= ppic_pkg::RST_ZERO;
			gboth_ff <= ppic_pkg::RST_ZERO;
			fer_ff <= ppic_pkg::RST_ZERO;
			mux_ff <= 64'h0;
		end
		else if (wr)
		begin
			case (PADDR_I)
				ppic_pkg::OFF_DIR: dir_ff <= PWDATA_I;
				ppic_pkg::OFF_DATA: data_ff <= PWDATA_I;
				ppic_pkg::OFF_DATA_SET: data_ff <= data_ff | PWDATA_I;
				ppic_pkg::OFF_DATA_CLR: data_ff <= data_ff & ~PWDATA_I;
				ppic_pkg::OFF_GMASK: gmask_ff <= PWDATA_I;
				ppic_pkg::OFF_GEDGE: gedge_ff <= PWDATA_I;
				ppic_pkg::OFF_GBOTH: gboth_ff <= PWDATA_I;
				ppic_pkg::OFF_MUX_LO: mux_ff[31:0] <= PWDATA_I;
				ppic_pkg::OFF_MUX_HI: mux_ff[63:32] <= PWDATA_I;
				ppic_pkg::OFF_FER: fer_ff <= PWDATA_I;
				default: ;
			endcase
		end
	end

	// gpio event detection: inputs by hardware, software trigger for all
	always_comb
	begin
		for (int i = 0; i < 32; i++)
		begin
			if (!gedge_ff[i])
				ghit[i] = ~dir_ff[i] & pins32[i];
			else if (gboth_ff[i])
				ghit[i] = ~dir_ff[i] & (pins32[i] ^ gprev_ff[i]);
			else
				ghit[i] = ~dir_ff[i] & pins32[i] & ~gprev_ff[i];
		end
	end

	// a clear that meets a fresh event in the same cycle loses, so
	// software never drops an event it has not yet seen; a level-mode
	// input that stays high sets its bit again at once
	// sticky status, write one clears, new event wins over clear
	always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			gstat_ff <= ppic_pkg::RST_ZERO;
		else if (wr && PADDR_I == ppic_pkg::OFF_GSTAT)
			gstat_ff <= (gstat_ff & ~PWDATA_I) | ghit | swtrig_ff;
		else
			gstat_ff <= gstat_ff | ghit | swtrig_ff;
	end

	// software trigger is a one-cycle pulse per written one
	always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			swtrig_ff <= ppic_pkg::RST_ZERO;
		else if (wr && PADDR_I == ppic_pkg::OFF_GSWTRIG)
			swtrig_ff <= PWDATA_I;
		else
			swtrig_ff <= 32'h0000_0000;
	end

	assign GPIO_IRQ_O = |(gstat_ff & gmask_ff);

	// with the function enable set the peripheral owns both level and
	// enable; the port data and direction bits are then ignored, but
	// the synchronised pin is always visible to the peripherals
	// pin drive: port function or selected peripheral
	genvar p;
	generate
		for (p = 0; p < NPINS; p++)
		begin : g_pin
			logic [1:0] fs;
			assign fs = mux_ff[p*2 +: 2];
			assign PIN_O[p] = fer_ff[p] ?
				PERIPH_OUT_I[{fs, 5'(p)}] : data_ff[p];
			assign PIN_OE_O[p] = fer_ff[p] ?
				PERIPH_OE_I[{fs, 5'(p)}] : dir_ff[p];
			assign PERIPH_IN_O[p] = pins32[p];
		end
	endgenerate

	// set and clear aliases let software touch single bits without a
	// read-modify-write, so two handlers cannot undo each other; the
	// polarity register is a plain write, the assign register too
	// channel registers: assign and polarity plain, mask and edge through set/clear aliases
	genvar c;
	generate
		for (c = 0; c < NCHAN; c++)
		begin : g_ch
			logic hit;
			logic [4:0] reg_off;
			assign hit = wr && is_chan(PADDR_I) && chan_of(PADDR_I) == c;
			assign reg_off = PADDR_I[4:0];
			assign ch_clr[c] = (hit && reg_off == ppic_pkg::CH_LATCH) ?
				PWDATA_I : 32'h0000_0000;
			always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
			begin
				if (!RESETN_I)
				begin
					ch_assign_ff[c] <= ppic_pkg::RST_ZERO;
					ch_mask_ff[c] <= ppic_pkg::RST_ZERO;
					ch_edge_ff[c] <= ppic_pkg::RST_ZERO;
					ch_inv_ff[c] <= ppic_pkg::RST_ZERO;
				end
				else if (hit)
				begin
					case (reg_off)
						ppic_pkg::CH_ASSIGN:
							ch_assign_ff[c] <= PWDATA_I;
						ppic_pkg::CH_MASK_SET:
							ch_mask_ff[c] <= ch_mask_ff[c] | PWDATA_I;
						ppic_pkg::CH_MASK_CLR:
							ch_mask_ff[c] <= ch_mask_ff[c] & ~PWDATA_I;
						ppic_pkg::CH_EDGE_SET:
							ch_edge_ff[c] <= ch_edge_ff[c] | PWDATA_I;
						ppic_pkg::CH_EDGE_CLR:
							ch_edge_ff[c] <= ch_edge_ff[c] & ~PWDATA_I;
						ppic_pkg::CH_INV_SET:
							ch_inv_ff[c] <= PWDATA_I;
						default: ;
					endcase
				end
			end
			// detection sees synchronised pins only, not dir or data
			ppic_chan #(.NPINS(NPINS)) u_chan (
				.clk_i(CLK_SYS_I),
				.rst_n_i(RESETN_I),
				.pins_i(pins32),
				.assign_i(ch_assign_ff[c]),
				.mask_i(ch_mask_ff[c]),
				.edge_i(ch_edge_ff[c]),
				.inv_i(ch_inv_ff[c]),
				.clr_i(ch_clr[c]),
				.pin_state_o(ch_pins[c]),
				.latch_o(ch_latch[c]),
				.irq_o(CHAN_IRQ_O[c])
			);
		end
	endgenerate

	// register window, byte offsets:
	// 00 direction, 1 = drive the pin
	// 04 output data
	// 08 data set alias, reads data
	// 0C data clear alias, reads data
	// 10 synchronised pin levels, read only
	// 14 gpio interrupt mask
	// 18 sensitivity, 1 = edge
	// 1C both edges when in edge mode
	// 20 software trigger, reads zero
	// 24 gpio status, write one to clear
	// 28 function select, pins 0 to 15
	// 2C function select, pins 16 to 31
	// 30 function enable
	// 34 to 3F hole, refused with pslverr
	// channel c at 40 + c * 20:
	// +00 half-port assignment, one byte lane per group
	// +04 mask set alias, +08 mask clear alias
	// +0C pending requests, latch and mask
	// +10 latch, write one to clear
	// +14 edge set alias, +18 edge clear alias
	// +1C polarity invert
	// other channel offsets return the gathered pin state
	// read mux; unmapped addresses answer with pslverr
	always_comb
	begin
		int ci;
		ci = chan_of(PADDR_I);
		nxt_rdata = 32'h0000_0000;
		nxt_err = 1'b0;
		case (PADDR_I)
			ppic_pkg::OFF_DIR: nxt_rdata = dir_ff;
			ppic_pkg::OFF_DATA: nxt_rdata = data_ff;
			ppic_pkg::OFF_DATA_SET: nxt_rdata = data_ff;
			ppic_pkg::OFF_DATA_CLR: nxt_rdata = data_ff;
			ppic_pkg::OFF_PIN_IN: nxt_rdata = pins32;
			ppic_pkg::OFF_GMASK: nxt_rdata = gmask_ff;
			ppic_pkg::OFF_GEDGE: nxt_rdata = gedge_ff;
			ppic_pkg::OFF_GBOTH: nxt_rdata = gboth_ff;
			ppic_pkg::OFF_GSWTRIG: nxt_rdata = 32'h0000_0000;
			ppic_pkg::OFF_GSTAT: nxt_rdata = gstat_ff;
			ppic_pkg::OFF_MUX_LO: nxt_rdata = mux_ff[31:0];
			ppic_pkg::OFF_MUX_HI: nxt_rdata = mux_ff[63:32];
			ppic_pkg::OFF_FER: nxt_rdata = fer_ff;
			default:
			begin
				if (is_chan(PADDR_I))
				begin
					case (PADDR_I[4:0])
						ppic_pkg::CH_ASSIGN: nxt_rdata = ch_assign_ff[ci];
						ppic_pkg::CH_MASK_SET,
						ppic_pkg::CH_MASK_CLR: nxt_rdata = ch_mask_ff[ci];
						ppic_pkg::CH_REQ:
							nxt_rdata = ch_latch[ci] & ch_mask_ff[ci];
						ppic_pkg::CH_LATCH: nxt_rdata = ch_latch[ci];
						ppic_pkg::CH_EDGE_SET,
						ppic_pkg::CH_EDGE_CLR: nxt_rdata = ch_edge_ff[ci];
						ppic_pkg::CH_INV_SET: nxt_rdata = ch_inv_ff[ci];
						default: nxt_rdata = ch_pins[ci];
					endcase
				end
				else
					nxt_err = 1'b1;
			end
		endcase
	end

	// read data only stands in a read access phase, zero otherwise,
	// so a bus mux can or several slaves together
	assign PRDATA_O = rd ? nxt_rdata : 32'h0000_0000;
	assign PSLVERR_O = PSEL_I & PENABLE_I & nxt_err;
endmodule : ppic_top
`default_nettype wire

// ===== ppic_props.sv
// ppic_props: port-level assertions of the gpio and pin-interrupt block
`default_nettype none
module ppic_props #(
	parameter int NPINS = 32,
	parameter int NCHAN = 4
) (
	input wire logic CLK_SYS_I,
	input wire logic RESETN_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic PREADY_O,
	input wire logic PSLVERR_O,
	input wire logic [NPINS-1:0] PIN_I,
	input wire logic [NPINS-1:0] PIN_O,
	input wire logic [NPINS-1:0] PIN_OE_O,
	input wire logic GPIO_IRQ_O,
	input wire logic [NCHAN-1:0] CHAN_IRQ_O
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RESETN_I);
	// access and write strobes seen by the slave
	wire acc = PSEL_I && PENABLE_I;
	wire wr = acc && PWRITE_I;
	// an irq only drops after software touched the registers
	sequence s_recent_wr;
		$past(wr, 1) || $past(wr, 2) || $past(wr, 3);
	endsequence
	sequence s_pin_moved;
		$past(PIN_I, 1) != $past(PIN_I, 6);
	endsequence
	property p_ready; acc |-> PREADY_O; endproperty
	a_ready: assert property (p_ready) else $error("pready low");
	property p_idle; !(acc && !PWRITE_I) |-> PRDATA_O == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("rdata not zero");
	property p_unmap;
		acc && PADDR_I inside {[8'h34:8'h3F]} |->
			PSLVERR_O && (PWRITE_I || PRDATA_O == 32'h0);
	endproperty
	a_unmap: assert property (p_unmap) else $error("hole not refused");
	property p_mapped; acc && PADDR_I < 8'h34 |-> !PSLVERR_O; endproperty
	a_mapped: assert property (p_mapped) else $error("bad slverr");
	property p_noerr; !acc |-> !PSLVERR_O; endproperty
	a_noerr: assert property (p_noerr) else $error("slverr out of access");
	property p_rst;
		$rose(RESETN_I) |-> PIN_OE_O == '0 && PIN_O == '0 && !GPIO_IRQ_O
			&& CHAN_IRQ_O == '0;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	property p_gfall; $fell(GPIO_IRQ_O) |-> s_recent_wr; endproperty
	a_gfall: assert property (p_gfall) else $error("gpio irq lost");
	property p_cfall;
		($past(CHAN_IRQ_O) & ~CHAN_IRQ_O) != '0 |-> s_recent_wr;
	endproperty
	a_cfall: assert property (p_cfall) else $error("chan irq lost");
	property p_grise; $rose(GPIO_IRQ_O) |-> s_recent_wr or s_pin_moved;
	endproperty
	a_grise: assert property (p_grise) else $error("irq from nothing");
endmodule // ppic_props
`default_nettype wire

// ===== ppic_pin_model.sv
// ppic_pin_model: far-side pin drivers with a weak pull-down
`default_nettype none
module ppic_pin_model #(
	parameter int NPINS = 32
) (
	input wire logic [NPINS-1:0] pin_out_i,
	input wire logic [NPINS-1:0] pin_oe_i,
	input wire logic [NPINS-1:0] ext_lvl_i,
	input wire logic [NPINS-1:0] ext_en_i,
	output logic [NPINS-1:0] pin_lvl_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// port drive wins, then the enabled far-side driver; a pin neither side drives falls to the pull-down
	assign pin_lvl_o = (pin_oe_i & pin_out_i) |
		(~pin_oe_i & ext_en_i & ext_lvl_i);
endmodule // ppic_pin_model
`default_nettype wire

// ===== tb_top.sv
// tb_top: register-level bench of the port and pin-interrupt block
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] ext_lvl = 32'h0;
	logic [31:0] ext_en = 32'hFFFF_FF0F;
	logic [127:0] per_out = 128'h0;
	logic [127:0] per_oe = 128'h0;
	logic [31:0] prdata, pin_o, pin_oe, pin_lvl, q;
	logic pready, pslverr, girq, err;
	logic [3:0] cirq;
	logic [31:0] per_in;
	int num_errors = 0;
	int comparisons = 0;
	initial forever #20 clk = ~clk;
	ppic_top dut (.CLK_SYS_I(clk), .RESETN_I(rst_n), .PSEL_I(psel),
		.PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.PIN_I(pin_lvl), .PIN_O(pin_o), .PIN_OE_O(pin_oe),
		.PERIPH_OUT_I(per_out), .PERIPH_OE_I(per_oe), .PERIPH_IN_O(per_in),
		.GPIO_IRQ_O(girq), .CHAN_IRQ_O(cirq));
	ppic_pin_model u_pins (.pin_out_i(pin_o), .pin_oe_i(pin_oe),
		.ext_lvl_i(ext_lvl), .ext_en_i(ext_en), .pin_lvl_o(pin_lvl));
	task automatic print_verdict();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one apb transfer; an idle edge follows so calls never collide
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			num_errors++;
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		cmp32(q, exp);
	endtask
	// pin to irq takes three edges through the synchroniser
	task automatic settle();
		repeat (6) @(posedge clk);
	endtask
	function automatic logic [7:0] ca(input logic [4:0] r);
		return ppic_pkg::OFF_CH_BASE + {3'h0, r};
	endfunction
	initial
	begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(ppic_pkg::OFF_DIR, ppic_pkg::RST_ZERO);
		rd(ca(ppic_pkg::CH_ASSIGN), ppic_pkg::RST_ZERO);
		wr(ppic_pkg::OFF_DIR, 32'h0000_00F0);
		cmp32(pin_oe, 32'h0000_00F0);
		wr(ppic_pkg::OFF_DATA_SET, 32'h0000_00A5);
		wr(ppic_pkg::OFF_DATA_CLR, 32'h0000_0005);
		rd(ppic_pkg::OFF_DATA, 32'h0000_00A0);
		cmp32(pin_o & pin_oe, 32'h0000_00A0);
		ext_lvl <= 32'h0000_0300;
		settle();
		rd(ppic_pkg::OFF_PIN_IN, 32'h0000_03A0);
		cmp32(per_in, 32'h0000_03A0);
		// pins 8 and 4 edge sensitive, stale level status dropped
		wr(ppic_pkg::OFF_GEDGE, 32'h0000_0110);
		wr(ppic_pkg::OFF_GSTAT, 32'hFFFF_FFFF);
		wr(ppic_pkg::OFF_GMASK, 32'h0000_0110);
		cmp32({31'h0, girq}, 32'h0);
		ext_lvl <= 32'h0000_0200;
		settle();
		cmp32({31'h0, girq}, 32'h0);
		ext_lvl <= 32'h0000_0300;
		settle();
		cmp32({31'h0, girq}, 32'h1);
		rd(ppic_pkg::OFF_GSTAT, 32'h0000_0300);
		wr(ppic_pkg::OFF_GSTAT, 32'h0000_0100);
		cmp32({31'h0, girq}, 32'h0);
		wr(ppic_pkg::OFF_GBOTH, 32'h0000_0100);
		ext_lvl <= 32'h0000_0200;
		settle();
		cmp32({31'h0, girq}, 32'h1);
		wr(ppic_pkg::OFF_GSTAT, 32'h0000_0100);
		wr(ppic_pkg::OFF_DATA_SET, 32'h0000_0010);
		settle();
		cmp32({31'h0, girq}, 32'h0);
		wr(ppic_pkg::OFF_GSWTRIG, 32'h0000_0010);
		settle();
		cmp32({31'h0, girq}, 32'h1);
		// channel 0 takes half-port 1: pin 8 is its bit 0
		ext_lvl <= 32'h0;
		wr(ca(ppic_pkg::CH_ASSIGN), 32'h0000_0081);
		wr(ca(ppic_pkg::CH_EDGE_SET), 32'h1);
		wr(ca(ppic_pkg::CH_MASK_SET), 32'h1);
		cmp32({28'h0, cirq}, 32'h0);
		ext_lvl <= 32'h0000_0100;
		settle();
		cmp32({28'h0, cirq}, 32'h1);
		rd(ca(ppic_pkg::CH_REQ), 32'h1);
		wr(ca(ppic_pkg::CH_MASK_CLR), 32'h1);
		settle();
		cmp32({28'h0, cirq}, 32'h0);
		rd(ca(ppic_pkg::CH_LATCH), 32'h1);
		wr(ca(ppic_pkg::CH_LATCH), 32'h1);
		rd(ca(ppic_pkg::CH_LATCH), 32'h0);
		wr(ca(ppic_pkg::CH_MASK_SET), 32'h1);
		wr(ca(ppic_pkg::CH_INV_SET), 32'h1);
		ext_lvl <= 32'h0;
		settle();
		cmp32({28'h0, cirq}, 32'h1);
		// level mode: clearing while the pin is active refires
		wr(ca(ppic_pkg::CH_EDGE_CLR), 32'h1);
		wr(ca(ppic_pkg::CH_INV_SET), 32'h0);
		ext_lvl <= 32'h0000_0100;
		settle();
		wr(ca(ppic_pkg::CH_LATCH), 32'h1);
		rd(ca(ppic_pkg::CH_LATCH), 32'h1);
		wr(8'h34, 32'hFFFF_FFFF);
		cmp32({31'h0, err}, 32'h1);
		rd(8'h34, 32'h0);
		// pin 0 handed to peripheral function 2
		per_out[64] <= 1'b1;
		per_oe[64] <= 1'b1;
		wr(ppic_pkg::OFF_MUX_LO, 32'h0000_0002);
		wr(ppic_pkg::OFF_FER, 32'h0000_0001);
		cmp32({30'h0, pin_oe[0], pin_o[0]}, 32'h3);
		print_verdict();
	end
	// a hang is cut off well past the some 165 cycles needed
	initial
	begin
		repeat (3000) @(posedge clk);
		num_errors++;
		print_verdict();
	end
endmodule // tb_top
bind ppic_top ppic_props #(.NPINS(NPINS), .NCHAN(NCHAN)) u_props (
	.CLK_SYS_I(CLK_SYS_I), .RESETN_I(RESETN_I), .PSEL_I(PSEL_I),
	.PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
	.PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
	.PIN_I(PIN_I), .PIN_O(PIN_O), .PIN_OE_O(PIN_OE_O),
	.GPIO_IRQ_O(GPIO_IRQ_O), .CHAN_IRQ_O(CHAN_IRQ_O));
`default_nettype wire
